/* hdl/dslf_pkg.sv */
/*
  Constants, command codes and carrier types for the drive security lock block.
  Assumes a command front end that has already gathered the one data sector.
*/
// What this block does
// - password sector: word0 bit8 level, bit0 user/master, words 1-16 the password.
// - master revision codes 0000h-FFFDh accepted; factory FFFEh; reported as word 92.
// - user password at High level stored; lock armed; user or master unlocks.
// - user password at Maximum level; only user password unlocks by unlock command.
// - master set replaces master password and revision; lock flag and level kept.
// - set-password aborted while locked or frozen.
// - factory state: master password all 20h bytes, locking disabled.
// - after reset with lock armed, media access refused until unlock succeeds.
// - unlock with master id compares master at High, rejected at Maximum.
// - unlock with user id compares against stored user password.
// - attempt counter starts at five; failed unlock while locked aborts and decrements.
// - counter at zero aborts unlock and erase-unit until reset.
// - unlock while already unlocked leaves the counter unchanged.
// - while frozen, unlock and erase-prepare are aborted.
// - erase-prepare must directly precede erase-unit; only that pair erases.
// - at Maximum, master unlocks only through prepare then erase-unit, erasing data.
// - after freeze-lock, password changes refused until reset.
// - security feature support advertised in identify word 128.
// - frozen state left only by reset.
// - erase-unit not directly after erase-prepare is aborted.
package dslf_pkg;
  localparam int DSLF_PW_BYTES = 32;
  localparam int DSLF_LEVEL_BIT = 8;
  localparam int DSLF_ID_BIT = 0;
  localparam logic [7:0] DSLF_CMD_SET_PW = 8'hf1;
  localparam logic [7:0] DSLF_CMD_UNLOCK = 8'hf2;
  localparam logic [7:0] DSLF_CMD_ERASE_PREP = 8'hf3;
  localparam logic [7:0] DSLF_CMD_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] DSLF_CMD_FREEZE = 8'hf5;
  localparam logic [7:0] DSLF_CMD_DISABLE_PW = 8'hf6;
  localparam logic [7:0] DSLF_PW_FILL = 8'h20;
  localparam logic [15:0] DSLF_REV_FACTORY = 16'hfffe;
  localparam logic [15:0] DSLF_REV_MAX_VALID = 16'hfffd;
  localparam logic [2:0] DSLF_TRIES_INIT = 3'h5;
  localparam logic [15:0] DSLF_WORD128_SUPPORTED = 16'h0001;
  localparam logic [15:0] DSLF_WORD128_ENABLED = 16'h0002;
  localparam logic [15:0] DSLF_WORD128_LOCKED = 16'h0004;
  localparam logic [15:0] DSLF_WORD128_FROZEN = 16'h0008;
  localparam logic [15:0] DSLF_WORD128_EXPIRED = 16'h0010;
  localparam logic [15:0] DSLF_WORD128_MAXLVL = 16'h0100;

  typedef logic [DSLF_PW_BYTES*8-1:0] dslf_pw_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] control;
    dslf_pw_t password;
    logic [15:0] revision;
  } dslf_cmd_s;

  typedef struct packed {
    logic done;
    logic aborted;
  } dslf_resp_s;
endpackage : dslf_pkg

/* hdl/dslf_lock.sv */
/*
  Security lock state machine: takes one gathered security command per pulse
  and answers done/aborted one cycle later, and gates media access.
  Assumes cmd_valid is a one-cycle pulse synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dslf_lock
  import dslf_pkg::*;
(
  input wire logic ref_clk, // 40 MHz controller clock
  input wire logic rst, // synchronous, active high power-on/hard reset
  input wire logic cmd_valid, // one-cycle pulse, a command is offered
  input wire dslf_cmd_s cmd, // opcode, control word, password, revision
  input wire logic media_req, // pulse, a media access command is offered
  output logic media_grant, // pulse, media access executes
  output logic media_refuse, // pulse, media access aborted
  output dslf_resp_s resp, // done and aborted pulses for security commands
  output logic erase_start, // pulse, erase all user data
  output logic [15:0] id_word92, // master password revision code
  output logic [15:0] id_word128 // security status word
);
  typedef enum {DSLF_UNLOCKED, DSLF_LOCKED} dslf_mode_e;

  dslf_mode_e mode_reg;
  dslf_pw_t user_pw_reg;
  dslf_pw_t master_pw_reg;
  logic [15:0] rev_reg;
  logic enabled_reg;
  logic max_level_reg;
  logic frozen_reg;
  logic prepared_reg;
  logic [2:0] tries_reg;

  function automatic logic pw_equal(input dslf_pw_t a, input dslf_pw_t b);
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < DSLF_PW_BYTES; i++) begin
      if (a[i*8 +: 8] != b[i*8 +: 8]) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction : pw_equal

  logic is_master;
  logic user_match;
  logic master_match;
  logic expired;
  logic unlock_ok;
  logic erase_ok;
  logic set_ok;
  logic abort_now;
  logic ok_now;

  assign is_master = cmd.control[DSLF_ID_BIT];
  assign user_match = pw_equal(cmd.password, user_pw_reg);
  assign master_match = pw_equal(cmd.password, master_pw_reg);
  assign expired = (tries_reg == 3'h0);
  // master at maximum level never unlocks by the unlock command
  assign unlock_ok = is_master ? (!max_level_reg && master_match) : user_match;
  assign erase_ok = prepared_reg && !frozen_reg && !expired
                    && (is_master ? master_match : user_match);
  assign set_ok = (mode_reg == DSLF_UNLOCKED) && !frozen_reg
                  && !(is_master && cmd.revision > DSLF_REV_MAX_VALID);

  always_comb begin
    ok_now = 1'b0;
    case (cmd.opcode)
      DSLF_CMD_SET_PW: ok_now = set_ok;
      DSLF_CMD_UNLOCK: ok_now = !frozen_reg && !expired
                                && (mode_reg == DSLF_UNLOCKED || unlock_ok);
      DSLF_CMD_ERASE_PREP: ok_now = !frozen_reg;
      DSLF_CMD_ERASE_UNIT: ok_now = erase_ok;
      DSLF_CMD_FREEZE: ok_now = (mode_reg == DSLF_UNLOCKED);
      DSLF_CMD_DISABLE_PW: ok_now = (mode_reg == DSLF_UNLOCKED) && !frozen_reg
                                    && (user_match || master_match);
      default: ok_now = 1'b0;
    endcase
    abort_now = cmd_valid && !ok_now;
  end

  // lock mode: armed flag turns into locked only at reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= enabled_reg ? DSLF_LOCKED : DSLF_UNLOCKED;
    end else if (cmd_valid && ok_now) begin
      case (cmd.opcode)
        DSLF_CMD_UNLOCK, DSLF_CMD_ERASE_UNIT: mode_reg <= DSLF_UNLOCKED;
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // stored passwords survive reset; only the factory state is a power-up value
  logic factory_done_reg = 1'b0;
  always_ff @(posedge ref_clk) begin
    if (!factory_done_reg) begin
      factory_done_reg <= 1'b1;
      master_pw_reg <= {DSLF_PW_BYTES{DSLF_PW_FILL}};
      user_pw_reg <= '0;
      rev_reg <= DSLF_REV_FACTORY;
      enabled_reg <= 1'b0;
      max_level_reg <= 1'b0;
    end else if (!rst && cmd_valid && ok_now) begin
      case (cmd.opcode)
        DSLF_CMD_SET_PW: begin
          if (is_master) begin
            master_pw_reg <= cmd.password;
            rev_reg <= cmd.revision;
          end else begin
            user_pw_reg <= cmd.password;
            enabled_reg <= 1'b1;
            max_level_reg <= cmd.control[DSLF_LEVEL_BIT];
          end
        end
        DSLF_CMD_ERASE_UNIT, DSLF_CMD_DISABLE_PW: enabled_reg <= 1'b0;
        default: enabled_reg <= enabled_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frozen_reg <= 1'b0;
    end else if (cmd_valid && ok_now && cmd.opcode == DSLF_CMD_FREEZE) begin
      frozen_reg <= 1'b1;
    end
  end

  // any command other than an accepted erase-prepare, erase-unit included, and any media access without a command in the same cycle break the prepare pairing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prepared_reg <= 1'b0;
    end else if (cmd_valid) begin
      prepared_reg <= (cmd.opcode == DSLF_CMD_ERASE_PREP) && ok_now;
    end else if (media_req) begin
      prepared_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tries_reg <= DSLF_TRIES_INIT;
    end else if (cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && mode_reg == DSLF_LOCKED
                 && !frozen_reg && !expired && !unlock_ok) begin
      tries_reg <= tries_reg - 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resp <= '0;
      erase_start <= 1'b0;
      media_grant <= 1'b0;
      media_refuse <= 1'b0;
    end else begin
      resp.done <= cmd_valid && ok_now;
      resp.aborted <= abort_now;
      erase_start <= cmd_valid && ok_now && cmd.opcode == DSLF_CMD_ERASE_UNIT;
      media_grant <= media_req && mode_reg == DSLF_UNLOCKED;
      media_refuse <= media_req && mode_reg == DSLF_LOCKED;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      id_word92 <= DSLF_REV_FACTORY;
      id_word128 <= DSLF_WORD128_SUPPORTED;
    end else begin
      id_word92 <= rev_reg;
      id_word128 <= DSLF_WORD128_SUPPORTED
        | (enabled_reg ? DSLF_WORD128_ENABLED : 16'h0000)
        | (mode_reg == DSLF_LOCKED ? DSLF_WORD128_LOCKED : 16'h0000)
        | (frozen_reg ? DSLF_WORD128_FROZEN : 16'h0000)
        | (expired ? DSLF_WORD128_EXPIRED : 16'h0000)
        | (max_level_reg ? DSLF_WORD128_MAXLVL : 16'h0000);
    end
  end

  property p_locked_refuse;
    @(posedge ref_clk) disable iff (rst)
      (media_req && mode_reg == DSLF_LOCKED) |=> media_refuse && !media_grant;
  endproperty
  a_locked_media_refused: assert property (p_locked_refuse)
    else $error("media access granted while locked");

  a_set_abort_locked: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_SET_PW && (frozen_reg || mode_reg == DSLF_LOCKED))
      |=> resp.aborted)
    else $error("set password not aborted while locked or frozen");

  a_tries_decrement: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && mode_reg == DSLF_LOCKED && !frozen_reg
     && !expired && !unlock_ok) |=> tries_reg == $past(tries_reg) - 3'h1 && resp.aborted)
    else $error("failed unlock did not decrement counter");

  a_expired_aborts: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && expired && (cmd.opcode == DSLF_CMD_UNLOCK || cmd.opcode == DSLF_CMD_ERASE_UNIT))
      |=> resp.aborted && !erase_start)
    else $error("command accepted with zero attempts left");

  a_unlocked_tries_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && mode_reg == DSLF_UNLOCKED)
      |=> $stable(tries_reg))
    else $error("unlock while unlocked changed counter");

  a_frozen_aborts: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && frozen_reg && (cmd.opcode == DSLF_CMD_UNLOCK
     || cmd.opcode == DSLF_CMD_ERASE_PREP)) |=> resp.aborted)
    else $error("unlock or prepare accepted while frozen");

  a_max_master_reject: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && is_master && max_level_reg
     && mode_reg == DSLF_LOCKED) |=> resp.aborted && mode_reg == DSLF_LOCKED)
    else $error("master unlock accepted at maximum level");

  sequence s_prep_ok;
    cmd_valid && cmd.opcode == DSLF_CMD_ERASE_PREP && ok_now;
  endsequence
  a_erase_needs_prep: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_ERASE_UNIT && !prepared_reg) |=> resp.aborted)
    else $error("erase unit without prepare accepted");
  a_prep_arms: assert property (@(posedge ref_clk) disable iff (rst)
    s_prep_ok |=> prepared_reg)
    else $error("prepare did not arm erase");
  a_frozen_sticks: assert property (@(posedge ref_clk) disable iff (rst)
    frozen_reg |=> frozen_reg)
    else $error("frozen state left without reset");

  // every offered command gets exactly one answer pulse; a host counts on that
  a_resp_one_hot: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_valid |=> resp.done != resp.aborted)
    else $error("command answer not exactly one pulse");
  a_resp_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !cmd_valid |=> !resp.done && !resp.aborted && !erase_start)
    else $error("answer pulse without a command");
  a_media_one_hot: assert property (@(posedge ref_clk) disable iff (rst)
    media_req |=> media_grant != media_refuse)
    else $error("media access answer not exactly one pulse");
  a_media_unlocked: assert property (@(posedge ref_clk) disable iff (rst)
    (media_req && mode_reg == DSLF_UNLOCKED) |=> media_grant)
    else $error("media access refused while unlocked");
  sequence s_set_user_ok;
    cmd_valid && cmd.opcode == DSLF_CMD_SET_PW && !is_master && set_ok;
  endsequence
  sequence s_set_master_ok;
    cmd_valid && cmd.opcode == DSLF_CMD_SET_PW && is_master && set_ok;
  endsequence
  // arming must not lock at once; locking waits for the next reset
  a_user_set_arms: assert property (@(posedge ref_clk) disable iff (rst)
    s_set_user_ok |=> enabled_reg && user_pw_reg == $past(cmd.password)
      && $stable(mode_reg))
    else $error("user password not stored or lock armed early");
  a_level_stored: assert property (@(posedge ref_clk) disable iff (rst)
    s_set_user_ok |=> max_level_reg == $past(cmd.control[DSLF_LEVEL_BIT]))
    else $error("security level not taken from the control word");
  a_master_set_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    s_set_master_ok |=> master_pw_reg == $past(cmd.password)
      && rev_reg == $past(cmd.revision) && $stable(enabled_reg) && $stable(max_level_reg))
    else $error("master set changed lock flag or level");
  a_revision_refused: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_SET_PW && is_master
     && cmd.revision > DSLF_REV_MAX_VALID) |=> resp.aborted && $stable(rev_reg))
    else $error("reserved master revision code accepted");
  a_word92_follows: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> id_word92 == $past(rev_reg))
    else $error("revision word does not follow the stored code");
  // no reset qualifier: the factory load happens whether or not rst is high
  a_factory_state: assert property (@(posedge ref_clk)
    $rose(factory_done_reg) |-> master_pw_reg == {DSLF_PW_BYTES{DSLF_PW_FILL}}
      && rev_reg == DSLF_REV_FACTORY && !enabled_reg)
    else $error("factory password state not loaded");
  a_lock_at_reset: assert property (@(posedge ref_clk)
    (rst && factory_done_reg) |=> (mode_reg == DSLF_LOCKED) == $past(enabled_reg))
    else $error("lock mode not taken from the armed flag at reset");
  sequence s_master_high_unlock;
    cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && is_master && !max_level_reg
      && mode_reg == DSLF_LOCKED && !frozen_reg && !expired && master_match;
  endsequence
  a_master_high_unlocks: assert property (@(posedge ref_clk) disable iff (rst)
    s_master_high_unlock |=> resp.done && mode_reg == DSLF_UNLOCKED)
    else $error("master unlock refused at high level");
  a_user_unlocks: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && !is_master && mode_reg == DSLF_LOCKED
     && !frozen_reg && !expired && user_match) |=> resp.done && mode_reg == DSLF_UNLOCKED)
    else $error("matching user unlock refused");
  a_partial_mismatch: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK && !is_master && mode_reg == DSLF_LOCKED
     && cmd.password != user_pw_reg) |=> resp.aborted && mode_reg == DSLF_LOCKED)
    else $error("unlock accepted with a differing password byte");
  sequence s_erase_ok;
    cmd_valid && cmd.opcode == DSLF_CMD_ERASE_UNIT && prepared_reg && !frozen_reg && !expired
      && (is_master ? master_match : user_match);
  endsequence
  a_erase_unlocks: assert property (@(posedge ref_clk) disable iff (rst)
    s_erase_ok |=> erase_start && resp.done && mode_reg == DSLF_UNLOCKED && !enabled_reg)
    else $error("prepared erase unit did not erase and unlock");
  a_media_breaks_pair: assert property (@(posedge ref_clk) disable iff (rst)
    (media_req && !cmd_valid) |=> !prepared_reg)
    else $error("media access did not end the prepare pairing");
  a_expired_sticks: assert property (@(posedge ref_clk) disable iff (rst)
    expired |=> expired)
    else $error("attempt counter left zero without reset");
  a_tries_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !(cmd_valid && cmd.opcode == DSLF_CMD_UNLOCK) |=> $stable(tries_reg))
    else $error("attempt counter moved without an unlock");
  a_frozen_no_change: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_valid && frozen_reg && cmd.opcode == DSLF_CMD_SET_PW)
      |=> resp.aborted && $stable(user_pw_reg) && $stable(master_pw_reg))
    else $error("password changed while frozen");
  a_word128_support: assert property (@(posedge ref_clk) disable iff (rst)
    (id_word128 & DSLF_WORD128_SUPPORTED) != 16'h0000)
    else $error("security support not advertised");
endmodule : dslf_lock
`default_nettype wire

/* test/dslf_host.sv */
/*
  host side model: issues security commands with their sector and media requests.
  assumes the block takes a request on the rising edge and answers one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module dslf_host
  import dslf_pkg::*;
(
  input wire logic ref_clk, // controller clock
  output logic cmd_valid, // command pulse
  output dslf_cmd_s cmd, // command and its sector
  output logic media_req // media access pulse
);
  initial begin
    cmd_valid = 1'b0;
    media_req = 1'b0;
    cmd = '0;
  end
  // one whole sector per command; once released the sector lines are scrambled
  task automatic issue(input logic [7:0] op, input logic [15:0] ctl, input dslf_pw_t pw,
                       input logic [15:0] rev);
    @(negedge ref_clk);
    cmd <= '{op, ctl, pw, rev};
    cmd_valid <= 1'b1;
    @(negedge ref_clk);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
  endtask : issue
  task automatic media();
    @(negedge ref_clk);
    media_req <= 1'b1;
    @(negedge ref_clk);
    media_req <= 1'b0;
  endtask : media
endmodule : dslf_host
`default_nettype wire

/* test/dslf_lock_tb.sv */
/*
  self-checking bench of the security lock block, driven through the host model.
  assumes stored passwords survive rst and factory values load at the first edge.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dslf_lock_tb;
  import dslf_pkg::*;
  typedef struct {
    logic [7:0] op;
    logic [15:0] ctl;
    dslf_pw_t pw;
    logic [15:0] rev;
    logic ab;
    logic [15:0] w92;
    logic [15:0] w128;
  } dslf_row_s;
  localparam dslf_pw_t PF = {32{8'h20}};
  localparam dslf_pw_t PU = {32{8'ha5}};
  localparam dslf_pw_t PM = {32{8'h3c}};
  localparam dslf_pw_t PB = {8'ha4, {31{8'ha5}}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, media_req, media_grant, media_refuse, erase_start;
  dslf_cmd_s cmd;
  dslf_resp_s resp;
  logic [15:0] id_word92, id_word128;
  int errors = 0;
  int checked = 0;
  dslf_row_s rows[8] = '{
    '{DSLF_CMD_SET_PW, 16'h0001, PM, 16'h0012, 1'b0, 16'h0012, 16'h0001},
    '{DSLF_CMD_SET_PW, 16'h0001, PM, 16'hfffe, 1'b1, 16'h0012, 16'h0001},
    '{DSLF_CMD_SET_PW, 16'h0001, PM, 16'hfffd, 1'b0, 16'hfffd, 16'h0001},
    '{DSLF_CMD_SET_PW, 16'h0000, PU, 16'h0000, 1'b0, 16'hfffd, 16'h0003},
    '{DSLF_CMD_UNLOCK, 16'h0000, PB, 16'h0000, 1'b0, 16'hfffd, 16'h0003},
    '{DSLF_CMD_ERASE_UNIT, 16'h0000, PU, 16'h0000, 1'b1, 16'hfffd, 16'h0003},
    '{DSLF_CMD_DISABLE_PW, 16'h0000, PU, 16'h0000, 1'b0, 16'hfffd, 16'h0001},
    '{DSLF_CMD_SET_PW, 16'h0100, PU, 16'h0000, 1'b0, 16'hfffd, 16'h0103}};
  always #12.5 ref_clk = ~ref_clk;
  dslf_host host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd), .media_req(media_req));
  dslf_lock uut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .media_req(media_req), .media_grant(media_grant), .media_refuse(media_refuse),
    .resp(resp), .erase_start(erase_start), .id_word92(id_word92), .id_word128(id_word128));
  task automatic end_of_test();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic reset_dut();
    @(negedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(negedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : reset_dut
  // the answer pulse stands for one cycle only, so it is read in the half cycle
  // after the taking edge; status words settle one edge later
  task automatic cmd_chk(input logic [7:0] op, input logic [15:0] ctl, input dslf_pw_t pw,
                         input logic [15:0] rev, input logic ab);
    host.issue(op, ctl, pw, rev);
    #1;
    `CHK(resp.aborted, ab)
    `CHK(resp.done, ~ab)
    `CHK(erase_start, 1'(op == DSLF_CMD_ERASE_UNIT && !ab))
    @(posedge ref_clk);
    #1;
  endtask : cmd_chk
  task automatic media_chk(input logic g);
    host.media();
    #1;
    `CHK(media_grant, g)
    `CHK(media_refuse, ~g)
  endtask : media_chk
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
  initial begin
    reset_dut();
    `CHK(id_word92, DSLF_REV_FACTORY)
    `CHK(id_word128, 16'h0001)
    cmd_chk(DSLF_CMD_SET_PW, 16'h0000, PU, 16'h0000, 1'b0);
    reset_dut();
    `CHK(id_word128, 16'h0007)
    media_chk(1'b0);
    cmd_chk(DSLF_CMD_UNLOCK, 16'h0001, PF, 16'h0000, 1'b0);
    `CHK(id_word128, 16'h0003)
    media_chk(1'b1);
    cmd_chk(DSLF_CMD_DISABLE_PW, 16'h0000, PU, 16'h0000, 1'b0);
    foreach (rows[i]) begin
      cmd_chk(rows[i].op, rows[i].ctl, rows[i].pw, rows[i].rev, rows[i].ab);
      `CHK(id_word92, rows[i].w92)
      `CHK(id_word128, rows[i].w128)
    end
    reset_dut();
    `CHK(id_word128, 16'h0107)
    cmd_chk(DSLF_CMD_SET_PW, 16'h0001, PM, 16'h0005, 1'b1);
    cmd_chk(DSLF_CMD_UNLOCK, 16'h0001, PM, 16'h0000, 1'b1);
    reset_dut();
    for (int i = 0; i < 5; i++) begin
      cmd_chk(DSLF_CMD_UNLOCK, 16'h0000, PB, 16'h0000, 1'b1);
      `CHK(id_word128[4], 1'(i == 4))
    end
    cmd_chk(DSLF_CMD_UNLOCK, 16'h0000, PU, 16'h0000, 1'b1);
    cmd_chk(DSLF_CMD_ERASE_PREP, 16'h0000, PU, 16'h0000, 1'b0);
    cmd_chk(DSLF_CMD_ERASE_UNIT, 16'h0001, PM, 16'h0000, 1'b1);
    reset_dut();
    cmd_chk(DSLF_CMD_ERASE_PREP, 16'h0000, PU, 16'h0000, 1'b0);
    cmd_chk(DSLF_CMD_ERASE_UNIT, 16'h0001, PM, 16'h0000, 1'b0);
    `CHK(id_word128[2:0], 3'h1)
    media_chk(1'b1);
    cmd_chk(DSLF_CMD_SET_PW, 16'h0000, PU, 16'h0000, 1'b0);
    cmd_chk(DSLF_CMD_ERASE_PREP, 16'h0000, PU, 16'h0000, 1'b0);
    media_chk(1'b1);
    cmd_chk(DSLF_CMD_ERASE_UNIT, 16'h0000, PU, 16'h0000, 1'b1);
    cmd_chk(DSLF_CMD_FREEZE, 16'h0000, PU, 16'h0000, 1'b0);
    `CHK(id_word128[3], 1'b1)
    cmd_chk(DSLF_CMD_SET_PW, 16'h0001, PM, 16'h0001, 1'b1);
    cmd_chk(DSLF_CMD_UNLOCK, 16'h0000, PU, 16'h0000, 1'b1);
    cmd_chk(DSLF_CMD_ERASE_PREP, 16'h0000, PU, 16'h0000, 1'b1);
    reset_dut();
    `CHK(id_word128[3:2], 2'b01)
    cmd_chk(DSLF_CMD_UNLOCK, 16'h0000, PU, 16'h0000, 1'b0);
    `CHK(id_word128[2], 1'b0)
    end_of_test();
  end
endmodule : dslf_lock_tb
`default_nettype wire
